// File: logic/pcsdec_pkg.sv
package pcsdec_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] BASE_REG_OFS = 8'ha4;
   localparam logic [7:0] AUX_REG_OFS = 8'ha8;
   localparam logic [7:0] STAT_REG_OFS = 8'hac;
   // ==========================================
   // Base register fields
   localparam int BASE_MSB = 15;
   localparam int BASE_LSB = 7;
   localparam int WAIT_EXT_BIT = 3;
   localparam int RDY_IGN_BIT = 2;
   localparam int WAIT_MSB = 1;
   localparam logic [15:0] RSVD_ONES = 16'h0070;
   // ==========================================
   // Auxiliary register fields
   localparam int PIN_FUNC_BIT = 7;
   localparam int SPACE_BIT = 6;
   localparam logic [15:0] AUX_RSVD_ONES = 16'h8038;
   // ==========================================
   // Address slicing: 256-byte slices, 2K-aligned block
   localparam int SLICE_LSB = 8;
   localparam int BLOCK_LSB = 11;
   localparam int NUM_SEL = 7;
   localparam int RSVD_SLICE = 4;
   // Extended wait encodings
   localparam logic [3:0] EXT_W0 = 4'h5;
   localparam logic [3:0] EXT_W1 = 4'h7;
   localparam logic [3:0] EXT_W2 = 4'h9;
   localparam logic [3:0] EXT_W3 = 4'hf;
   typedef enum {ST_IDLE, ST_WAIT, ST_READY} pcsdec_state_t;
endpackage : pcsdec_pkg

// File: logic/pcsdec_top.sv
// What this block does
// [R1] Selects follow multiplexed address/data timing
// [R2] Each select spans one 256-byte range
// [R3] Slices 0-3 consecutive, 4 reserved, 5/6 at 1280/1536
// [R4] Block in memory or 64K I/O space
// [R5] Selects inactive until both registers written
// [R6] Aux write alone enables address outputs
// [R7] Aux register sets space, upper ready/wait
// [R8] Lower selects 0-15 waits, upper 0-3
// [R9] Base register has no reset value
// [R10] Base bits 19-11 in register bits 15-7
// [R11] Bit 6 unused; software writes ones 6-4
// [R12] Software zeroes base 19-16 for I/O
// [R13] Extend clear: wait field gives 0-3
// [R14] Extend set: 5,7,9,15 wait states
// [R15] Ready-ignore bit drops external ready need
// [R16] Base ready/wait only for lower selects
// [R17] Select needs enable, space match, address hit
// [R18] Pin-function bit: selects or latched A1/A2
// [R19] Space bit: one memory, zero I/O
// [R20] Aux ready/wait govern only upper selects
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pcsdec_top (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [15:0] regRdData,
   input wire logic addrValid,
   input wire logic [19:0] busAddr,
   input wire logic busIsMem,
   input wire logic extReady,
   input wire logic cycleEnd,
   output logic [6:0] peripheralSelectLines_n,
   output logic cycleDone
);
   import pcsdec_pkg::*;

   typedef struct packed {
      logic [15:0] baseReg;
      logic [15:0] auxReg;
      logic baseWritten;
      logic auxWritten;
      logic [6:0] selN;
      logic [3:0] waitCnt;
      logic needRdy;
      logic done;
      logic [15:0] rdData;
      pcsdec_state_t state;
   } pcsdec_st_t;

   pcsdec_st_t cur_ff, nxt_cur;

   // ==========================================
   // Address decode
   logic [19:0] blockBase;
   logic spaceHit;
   logic [NUM_SEL-1:0] hit;
   logic lowEn;
   logic highEn;
   logic highSel;

   // Base register maps to A19..A11; lower base bits zero; reg bit 6 ignored
   assign blockBase = {cur_ff.baseReg[BASE_MSB:BASE_LSB], 11'h000}; // see [R10] see [R11]
   // Memory cycles when space bit set, else I/O cycles (16-bit address)
   assign spaceHit = cur_ff.auxReg[SPACE_BIT] ? busIsMem
      : (!busIsMem && busAddr[19:16] == 4'h0); // see [R4] see [R19] see [R12]
   assign lowEn = cur_ff.baseWritten && cur_ff.auxWritten; // see [R5]
   assign highEn = lowEn && cur_ff.auxReg[PIN_FUNC_BIT]; // see [R18]

   // Per-slice compare within the 2K block
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SEL; gi++) begin : g_slice
         assign hit[gi] = (gi != RSVD_SLICE) && addrValid && spaceHit
            && busAddr[19:BLOCK_LSB] == blockBase[19:BLOCK_LSB]
            && busAddr[BLOCK_LSB-1:SLICE_LSB] == 3'(gi)
            && ((gi < RSVD_SLICE) ? lowEn : highEn); // see [R2] see [R3] see [R17]
      end
   endgenerate
   assign highSel = hit[5] || hit[6];

   // Wait decode for lower selects
   function automatic logic [3:0] lowWaits(input logic [15:0] r);
      logic [3:0] w;
      w = 4'h0;
      if (r[WAIT_EXT_BIT]) begin
         unique case (r[WAIT_MSB:0])
            2'b00: w = EXT_W0; // see [R14]
            2'b01: w = EXT_W1;
            2'b10: w = EXT_W2;
            2'b11: w = EXT_W3;
         endcase
      end else begin
         w = {2'b00, r[WAIT_MSB:0]}; // see [R13]
      end
      return w;
   endfunction : lowWaits

   // ==========================================
   // Next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.done = 1'b0;
      nxt_cur.rdData = 16'h0000;
      // Register writes; reserved bits forced to ones
      if (regWrStb && regAddr == BASE_REG_OFS) begin
         nxt_cur.baseReg = regWrData | RSVD_ONES;
         nxt_cur.baseWritten = 1'b1;
      end
      if (regWrStb && regAddr == AUX_REG_OFS) begin
         nxt_cur.auxReg = regWrData | AUX_RSVD_ONES;
         nxt_cur.auxWritten = 1'b1; // see [R6]
      end
      // Read data valid one cycle after the strobe; unmapped reads zero
      if (regRdStb) begin
         unique case (regAddr)
            BASE_REG_OFS: nxt_cur.rdData = cur_ff.baseReg; // see [R9]
            AUX_REG_OFS: nxt_cur.rdData = cur_ff.auxReg;
            STAT_REG_OFS: nxt_cur.rdData = {11'h000, cur_ff.done, cur_ff.needRdy,
               cur_ff.auxWritten, cur_ff.baseWritten, cur_ff.state != ST_IDLE};
            default: nxt_cur.rdData = 16'h0000;
         endcase
      end
      // Selects registered from the multiplexed address phase
      nxt_cur.selN = ~hit; // see [R1]
      // Upper pins carry latched A1/A2 when configured as address
      if (cur_ff.auxWritten && !cur_ff.auxReg[PIN_FUNC_BIT]) begin
         nxt_cur.selN[5] = addrValid ? busAddr[1] : cur_ff.selN[5]; // see [R6] see [R18]
         nxt_cur.selN[6] = addrValid ? busAddr[2] : cur_ff.selN[6];
      end
      // Wait-state and ready sequencing
      unique case (cur_ff.state)
         ST_IDLE: begin
            if (|hit) begin
               if (highSel) begin
                  nxt_cur.waitCnt = {2'b00, cur_ff.auxReg[WAIT_MSB:0]}; // see [R8] see [R20]
                  nxt_cur.needRdy = !cur_ff.auxReg[RDY_IGN_BIT]; // see [R7] see [R16]
               end else begin
                  nxt_cur.waitCnt = lowWaits(cur_ff.baseReg); // see [R8] see [R16]
                  nxt_cur.needRdy = !cur_ff.baseReg[RDY_IGN_BIT]; // see [R15]
               end
               nxt_cur.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Programmed waits always run, even with ready ignored
            if (cur_ff.waitCnt == 4'h0) begin
               nxt_cur.state = ST_READY; // see [R15]
            end else begin
               nxt_cur.waitCnt = cur_ff.waitCnt - 4'h1;
            end
         end
         ST_READY: begin
            if (!cur_ff.needRdy || extReady) begin
               nxt_cur.done = 1'b1; // see [R15]
               nxt_cur.state = ST_IDLE;
            end
         end
      endcase
      // Bus cycle abort returns to idle; selects drop
      if (cycleEnd) begin
         nxt_cur.state = ST_IDLE;
         nxt_cur.selN[3:0] = 4'hf;
         if (cur_ff.auxReg[PIN_FUNC_BIT] || !cur_ff.auxWritten) begin
            nxt_cur.selN[6:4] = 3'h7;
         end
      end
      nxt_cur.selN[RSVD_SLICE] = 1'b1;
   end

   // ==========================================
   // State register; base/aux contents left as-is on reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cur_ff.baseWritten <= 1'b0; // see [R5]
         cur_ff.auxWritten <= 1'b0;
         cur_ff.selN <= 7'h7f;
         cur_ff.waitCnt <= 4'h0;
         cur_ff.needRdy <= 1'b0;
         cur_ff.done <= 1'b0;
         cur_ff.rdData <= 16'h0000;
         cur_ff.state <= ST_IDLE;
         cur_ff.baseReg <= nxt_cur.baseReg;
         cur_ff.auxReg <= nxt_cur.auxReg;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign regRdData = cur_ff.rdData;
   assign peripheralSelectLines_n = cur_ff.selN;
   assign cycleDone = cur_ff.done;
endmodule : pcsdec_top
`default_nettype wire

// File: tb/pcsdec_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checks
module pcsdec_assertions (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [15:0] regRdData,
   input wire logic addrValid,
   input wire logic [19:0] busAddr,
   input wire logic busIsMem,
   input wire logic extReady,
   input wire logic cycleEnd,
   input wire logic [6:0] peripheralSelectLines_n,
   input wire logic cycleDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_SEL4_OFF: assert property (peripheralSelectLines_n[4])
      else $error("sel4 low");
   AST_RST_IDLE: assert property ($past(reset) |-> &peripheralSelectLines_n && !cycleDone)
      else $error("active after reset");
   AST_ONE_LOW: assert property ($onehot0(~peripheralSelectLines_n[3:0]))
      else $error("two selects");
   AST_NEED_VALID: assert property (!(&peripheralSelectLines_n[3:0]) |-> $past(addrValid))
      else $error("select without address");
   AST_DONE_PULSE: assert property (cycleDone |=> !cycleDone)
      else $error("long done");
   AST_DONE_SEL: assert property (cycleDone |-> $past(peripheralSelectLines_n != 7'h7f))
      else $error("done unselected");
   AST_RD_UNMAP: assert property (regRdStb && !(regAddr inside {8'ha4, 8'ha8, 8'hac})
      |=> regRdData == 16'h0) else $error("unmapped data");
   AST_BASE_RSVD: assert property (regRdStb && regAddr == 8'ha4 |=> regRdData[6:4] == 3'h7)
      else $error("reserved bits");
endmodule : pcsdec_assertions
bind pcsdec_top pcsdec_assertions chk_i (.ref_clk, .reset, .regAddr, .regWrData, .regWrStb,
   .regRdStb, .regRdData, .addrValid, .busAddr, .busIsMem, .extReady, .cycleEnd,
   .peripheralSelectLines_n, .cycleDone);
`default_nettype wire

// File: tb/pcsdec_periph.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Slow peripheral: ready only after its lag, low while deselected
module pcsdec_periph (
   input wire logic ref_clk,
   input wire logic [6:0] selN,
   input wire logic [4:0] lag,
   output logic ready
);
   logic [4:0] cnt_ff = 5'h0;
   logic idle;
   assign idle = &selN[3:0] && &selN[6:5];
   // Count selected cycles, saturating at the lag
   always_ff @(posedge ref_clk) begin
      cnt_ff <= idle ? 5'h0 : cnt_ff + 5'((cnt_ff < lag) ? 1 : 0);
   end
   assign ready = !idle && cnt_ff >= lag;
endmodule : pcsdec_periph
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module tb;
   logic ref_clk = 1'b0, reset = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
   logic addrValid = 1'b0, busIsMem = 1'b0, cycleEnd = 1'b0, extReady, cycleDone;
   logic [7:0] regAddr = 8'h0;
   logic [15:0] regWrData = 16'h0, regRdData, base, aux;
   logic [19:0] busAddr = 20'h0, a;
   logic [6:0] peripheralSelectLines_n;
   logic [4:0] lag = 5'h0;
   int n_fail = 0, n_checks = 0, s;
   pcsdec_top dut (.ref_clk, .reset, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
      .addrValid, .busAddr, .busIsMem, .extReady, .cycleEnd, .peripheralSelectLines_n, .cycleDone);
   pcsdec_periph peer (.ref_clk, .selN(peripheralSelectLines_n), .lag, .ready(extReady));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // Expected wait count from extend bit and field
   function automatic int wx(input logic [3:0] r);
      return r[3] ? ((r[1:0] == 2'h3) ? 15 : 5 + 2 * r[1:0]) : r[1:0];
   endfunction : wx
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      regAddr <= ad; regWrData <= d; regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
      // Let one edge pass so a following call never re-drives the strobe in this step
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [15:0] e);
      regAddr <= ad; regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1 chk(regRdData === e, "read");
      @(posedge ref_clk);
   endtask : rd
   // One bus cycle; select index 7 means no select expected
   task automatic cyc(input logic m, input int sx, input int w);
      int n = 0;
      busAddr <= a; busIsMem <= m; addrValid <= 1'b1;
      @(posedge ref_clk);
      #1 chk(peripheralSelectLines_n === ~(7'h1 << sx), "select");
      while (sx < 7 && cycleDone !== 1'b1 && n < 40) begin
         @(posedge ref_clk); #1 n++;
      end
      if (n == 40) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, "cycle timeout");
         tally_and_finish();
      end
      // Done lands one state-machine cycle after the last wait state
      if (sx < 7) chk(lag ? n >= lag : n == w + 2, "waits");
      @(posedge ref_clk);
      addrValid <= 1'b0; cycleEnd <= 1'b1;
      @(posedge ref_clk);
      cycleEnd <= 1'b0;
   endtask : cyc
   initial begin
      void'($urandom(95));
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      a = 20'($urandom);
      cyc(1'b1, 7, 0);
      for (int i = 0; i < 32; i++) begin
         base = 16'($urandom); aux = 16'($urandom) & 16'h0007 | 16'h00c0;
         s = i % 8;
         wr(8'ha8, aux);
         wr(8'ha4, base);
         rd(8'ha4, base | 16'h0070);
         rd(8'ha8, aux | 16'h8038);
         a = {base[15:7], 11'h0} | 20'(s << 8) | 20'($urandom & 8'hff);
         cyc(1'b1, (s == 4) ? 7 : s, (s > 4) ? aux[1:0] : wx(base[3:0]));
      end
      rd(8'h10, 16'h0);
      wr(8'ha8, 16'h0084);
      base = 16'($urandom) & 16'h0ff0;
      wr(8'ha4, base);
      a = {base[15:7], 11'h0};
      cyc(1'b1, 7, 0);
      cyc(1'b0, 0, 0);
      lag <= 5'd20;
      cyc(1'b0, 0, 0);
      // Address mode: upper pins carry latched A1/A2 after an aux write
      wr(8'ha8, 16'h0040);
      busAddr <= 20'h00002; addrValid <= 1'b1;
      @(posedge ref_clk);
      #1 chk(peripheralSelectLines_n[6:5] === 2'b01, "address pins");
      @(posedge ref_clk);
      addrValid <= 1'b0;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
